// ==== adc_host_pkg.sv ====
// package of constants for the converter bus host sequencer
package adc_host_pkg;
    // ==========================================
    // storage and sequence
    localparam int unsigned DATA_W = 8;
    localparam int unsigned BURST_LEN = 16;
    localparam logic [7:0] STORE_BASE = 8'h20;
    localparam logic [7:0] STORE_LAST = 8'h2F;
    localparam logic [7:0] PORT_ADDR = 8'hE0;
    localparam logic [15:0] RESTART_VECTOR = 16'h0038;
    localparam logic [7:0] RESTART_OPCODE = 8'hFF;
    localparam logic [15:0] DUMMY_ADDR = 16'hFFFF;
    // ==========================================
    // strobe timing (ns) and derived cycles at 25 MHz
    localparam int unsigned CLK_PERIOD_NS = 40;
    localparam int unsigned STROBE_NS = 200;
    localparam int unsigned STROBE_CYC = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned WAIT_NS = 120000;
    localparam int unsigned WAIT_CYC = WAIT_NS / CLK_PERIOD_NS;
    // ==========================================
    // select source modes and sequence states
    localparam logic [1:0] MAP_MEMORY = 2'h0;
    localparam logic [1:0] MAP_IO_LOW = 2'h1;
    localparam logic [1:0] MAP_IO_HIGH = 2'h2;
    localparam logic [1:0] MAP_PORT_PIN = 2'h3;
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_START,
        ST_WAIT,
        ST_ACK,
        ST_READ,
        ST_STORE,
        ST_DONE
    } seq_state_t;
endpackage

// ==== sample_fifo.sv ====
// small synchronous fifo for converted samples
`timescale 1ns/1ps
module sample_fifo #(
    parameter int unsigned WIDTH = 16,
    parameter int unsigned DEPTH = 16
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int unsigned AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr_r;
    logic [AW-1:0] rd_ptr_r;
    logic [AW:0] count_r;
    logic push;
    logic pop;
    assign in_ready = (count_r != (AW+1)'(DEPTH));
    assign out_valid = (count_r != '0);
    assign out_data = mem[rd_ptr_r];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    always_ff @(posedge clk)
    begin
        if (push)
        begin
            mem[wr_ptr_r] <= in_data;
        end
    end
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r <= '0;
        end
        else
        begin
            if (push)
            begin
                wr_ptr_r <= (wr_ptr_r == AW'(DEPTH - 1)) ? '0 : wr_ptr_r + 1'b1;
            end
            if (pop)
            begin
                rd_ptr_r <= (rd_ptr_r == AW'(DEPTH - 1)) ? '0 : rd_ptr_r + 1'b1;
            end
            count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule // sample_fifo

// ==== adc_bus_host_sequencer.sv ====
// host sequencer that drives the converter pins and collects a burst of samples
`timescale 1ns/1ps
// Overview of operation
// [R1] memory map: select from memory decode, memory read and write strobes used
// [R2] i/o map: i/o strobes, select decoded from low or high address byte
// [R3] select, read, write go straight to converter; write starts, read returns data
// [R4] up to eight i/o devices may use a low address bit as select; index 0 here gets port address E0E0, not bit 0
// [R5] converter is an 8-bit port at a chosen address; out starts, in reads
// [R6] on completion interrupt read port, store at pointer, bump pointer, restart
// [R7] collect 16 bytes at locations 20 to 2F hex, then stop and hand over
// [R8] port-pin variant: select comes from bit 0 of an output port
// [R9] port-pin variant: strobes come from dummy address accesses with select low
// [R10] interrupt acknowledge supplies restart instruction vectoring to 0038
// [R11] converter output is straight binary, coarse plus fine nibble
// [R12] select-qualified read clears the pending completion interrupt
// [R13] restart during conversion aborts it; old result kept, interrupt stays high
// [R14] never read the result between a start and its completion interrupt
module adc_bus_host_sequencer #(
    parameter int unsigned FIFO_DEPTH = 16,
    parameter int unsigned WAIT_LIMIT = adc_host_pkg::WAIT_CYC
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // user side
    input wire logic go,
    input wire logic [1:0] map_mode,
    input wire logic [2:0] dev_index,
    output logic busy,
    output logic done,
    output logic timeout,
    // sample stream out
    output logic sample_valid,
    input wire logic sample_ready,
    output logic [7:0] sample_addr,
    output logic [7:0] sample_data,
    output logic [3:0] coarse_nibble_voltage,
    output logic [3:0] fine_nibble_voltage,
    // converter pins
    output logic cs_b,
    output logic rd_b,
    output logic wr_b,
    input wire logic intr_b,
    input wire logic [7:0] db_in,
    // system bus view
    output logic [15:0] addr,
    output logic memory_read_strobe,
    output logic memory_write_strobe,
    output logic io_read_strobe,
    output logic io_write_strobe,
    output logic port_pin0,
    output logic inta,
    output logic [7:0] ack_opcode,
    output logic [15:0] vector_addr
);
    // ==========================================
    // helper function
    function automatic logic [15:0] select_addr(input logic [1:0] mode, input logic [2:0] idx);
        logic [15:0] a;
        a = {adc_host_pkg::PORT_ADDR, adc_host_pkg::PORT_ADDR};
        if (mode == adc_host_pkg::MAP_IO_LOW && idx != 3'h0)
        begin
            a = {8'h00, ~(8'h01 << idx)};
        end
        return a;
    endfunction

    adc_host_pkg::seq_state_t state_r;
    adc_host_pkg::seq_state_t state_nxt;
    logic [3:0] strobe_cnt_r;
    logic [31:0] wait_cnt_r;
    logic [7:0] ptr_r;
    logic [4:0] count_r;
    logic [7:0] data_r;
    logic [1:0] mode_r;
    logic [2:0] idx_r;
    logic strobe_end;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic [15:0] fifo_out_data;
    logic push;
    logic [1:0] mode_now;
    logic [2:0] idx_now;
    assign strobe_end = (strobe_cnt_r == 4'(adc_host_pkg::STROBE_CYC - 1));
    assign push = (state_r == adc_host_pkg::ST_STORE) && fifo_in_ready;
    assign mode_now = (state_r == adc_host_pkg::ST_IDLE) ? map_mode : mode_r;
    assign idx_now = (state_r == adc_host_pkg::ST_IDLE) ? dev_index : idx_r;
    // ==========================================
    // sequence state
    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            adc_host_pkg::ST_IDLE:
                if (go)
                    state_nxt = adc_host_pkg::ST_START;
            adc_host_pkg::ST_START:
                if (strobe_end)
                    state_nxt = adc_host_pkg::ST_WAIT;
            adc_host_pkg::ST_WAIT:
                if (!intr_b)
                    state_nxt = adc_host_pkg::ST_ACK; // R14
                else if (wait_cnt_r == WAIT_LIMIT - 1)
                    state_nxt = adc_host_pkg::ST_DONE;
            adc_host_pkg::ST_ACK:
                state_nxt = adc_host_pkg::ST_READ; // R10
            adc_host_pkg::ST_READ:
                if (strobe_end)
                    state_nxt = adc_host_pkg::ST_STORE; // R6
            adc_host_pkg::ST_STORE:
            begin
                if (fifo_in_ready)
                begin
                    if (count_r == 5'(adc_host_pkg::BURST_LEN - 1))
                    begin
                        state_nxt = adc_host_pkg::ST_DONE; // R7
                    end
                    else
                    begin
                        state_nxt = adc_host_pkg::ST_START; // R6
                    end
                end
            end
            adc_host_pkg::ST_DONE:
                state_nxt = adc_host_pkg::ST_IDLE;
            default:
                state_nxt = adc_host_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state_r <= adc_host_pkg::ST_IDLE;
        end
        else
        begin
            state_r <= state_nxt;
        end
    end

    // ==========================================
    // counters and pointer
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            strobe_cnt_r <= '0;
            wait_cnt_r <= '0;
            ptr_r <= adc_host_pkg::STORE_BASE;
            count_r <= '0;
            mode_r <= adc_host_pkg::MAP_MEMORY;
            idx_r <= '0;
        end
        else
        begin
            strobe_cnt_r <= (state_nxt != state_r) ? '0 : strobe_cnt_r + 4'h1;
            wait_cnt_r <= (state_r == adc_host_pkg::ST_WAIT) ? wait_cnt_r + 32'h1 : '0;
            if (state_r == adc_host_pkg::ST_IDLE && go)
            begin
                ptr_r <= adc_host_pkg::STORE_BASE; // R7
                count_r <= '0;
                mode_r <= map_mode;
                idx_r <= dev_index;
            end
            else if (push)
            begin
                ptr_r <= ptr_r + 8'h01; // R6
                count_r <= count_r + 5'h01;
            end
        end
    end

    // ==========================================
    // data capture at end of read strobe
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            data_r <= '0;
        end
        else if (state_r == adc_host_pkg::ST_READ && strobe_end)
        begin
            data_r <= db_in; // R5
        end
    end

    // ==========================================
    // converter and bus pins
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            cs_b <= 1'b1;
            rd_b <= 1'b1;
            wr_b <= 1'b1;
            addr <= '0;
            memory_read_strobe <= 1'b0;
            memory_write_strobe <= 1'b0;
            io_read_strobe <= 1'b0;
            io_write_strobe <= 1'b0;
            port_pin0 <= 1'b1;
            inta <= 1'b0;
            ack_opcode <= '0;
            vector_addr <= '0;
        end
        else
        begin
            // R3: select, read, write go straight to the converter pins
            cs_b <= !(state_nxt == adc_host_pkg::ST_START || state_nxt == adc_host_pkg::ST_READ);
            wr_b <= !(state_nxt == adc_host_pkg::ST_START); // R3
            rd_b <= !(state_nxt == adc_host_pkg::ST_READ); // R12
            addr <= (mode_now == adc_host_pkg::MAP_PORT_PIN) ? adc_host_pkg::DUMMY_ADDR
                    : select_addr(mode_now, idx_now); // R2 R4 R9
            memory_write_strobe <= (mode_now == adc_host_pkg::MAP_MEMORY)
                    && state_nxt == adc_host_pkg::ST_START; // R1
            memory_read_strobe <= (mode_now == adc_host_pkg::MAP_MEMORY)
                    && state_nxt == adc_host_pkg::ST_READ; // R1
            io_write_strobe <= (mode_now != adc_host_pkg::MAP_MEMORY)
                    && state_nxt == adc_host_pkg::ST_START; // R2
            io_read_strobe <= (mode_now != adc_host_pkg::MAP_MEMORY)
                    && state_nxt == adc_host_pkg::ST_READ; // R2
            port_pin0 <= !((mode_now == adc_host_pkg::MAP_PORT_PIN)
                    && (state_nxt == adc_host_pkg::ST_START
                    || state_nxt == adc_host_pkg::ST_READ)); // R8
            inta <= (state_nxt == adc_host_pkg::ST_ACK); // R10
            ack_opcode <= (state_nxt == adc_host_pkg::ST_ACK) ? adc_host_pkg::RESTART_OPCODE : '0;
            vector_addr <= (state_nxt == adc_host_pkg::ST_ACK) ? adc_host_pkg::RESTART_VECTOR : '0;
        end
    end

    // ==========================================
    // status
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            busy <= 1'b0;
            done <= 1'b0;
            timeout <= 1'b0;
        end
        else
        begin
            busy <= (state_nxt != adc_host_pkg::ST_IDLE);
            done <= (state_nxt == adc_host_pkg::ST_DONE);
            if (state_r == adc_host_pkg::ST_IDLE && go)
            begin
                timeout <= 1'b0;
            end
            else if (state_r == adc_host_pkg::ST_WAIT && state_nxt == adc_host_pkg::ST_DONE)
            begin
                timeout <= 1'b1;
            end
        end
    end

    // ==========================================
    // sample buffer
    sample_fifo #(
        .WIDTH(16),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk(clk),
        .rst_b(rst_b),
        .in_valid(state_r == adc_host_pkg::ST_STORE),
        .in_ready(fifo_in_ready),
        .in_data({ptr_r, data_r}),
        .out_valid(fifo_out_valid),
        .out_ready(sample_ready && !sample_valid),
        .out_data(fifo_out_data)
    );

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            sample_valid <= 1'b0;
            sample_addr <= '0;
            sample_data <= '0;
            coarse_nibble_voltage <= '0;
            fine_nibble_voltage <= '0;
        end
        else if (sample_valid)
        begin
            sample_valid <= 1'b0;
        end
        else if (fifo_out_valid && sample_ready)
        begin
            sample_valid <= 1'b1;
            sample_addr <= fifo_out_data[15:8];
            sample_data <= fifo_out_data[7:0];
            coarse_nibble_voltage <= fifo_out_data[7:4]; // R11
            fine_nibble_voltage <= fifo_out_data[3:0]; // R11
        end
    end
endmodule // adc_bus_host_sequencer

// ==== adc_bus_host_sequencer_properties.sv ====
// concurrent checks on the converter bus host sequencer ports
`timescale 1ns/1ps
module adc_host_checker (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // user side
    input wire logic busy,
    input wire logic done,
    input wire logic sample_valid,
    input wire logic [7:0] sample_addr,
    input wire logic [7:0] sample_data,
    input wire logic [3:0] coarse_nibble_voltage,
    input wire logic [3:0] fine_nibble_voltage,
    // converter pins
    input wire logic cs_b,
    input wire logic rd_b,
    input wire logic wr_b,
    input wire logic intr_b,
    // system bus view
    input wire logic [15:0] addr,
    input wire logic memory_read_strobe,
    input wire logic memory_write_strobe,
    input wire logic io_read_strobe,
    input wire logic io_write_strobe,
    input wire logic port_pin0,
    input wire logic inta,
    input wire logic [7:0] ack_opcode,
    input wire logic [15:0] vector_addr
);
    // ==========================================
    // properties
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);
    wr_width_a: assert property ($fell(wr_b) |-> !wr_b [*5] ##1 wr_b)
        else $error("write strobe width wrong");
    rd_width_a: assert property ($fell(rd_b) |-> (!rd_b && !cs_b) [*5] ##1 rd_b)
        else $error("read strobe width wrong");
    ack_after_intr_a: assert property ($rose(inta) |-> !$past(intr_b))
        else $error("acknowledge without interrupt");
    read_after_ack_a: assert property ($fell(rd_b) |-> $past(inta))
        else $error("read not preceded by acknowledge");
    ack_vector_a: assert property (inta |-> ack_opcode == adc_host_pkg::RESTART_OPCODE
        && vector_addr == adc_host_pkg::RESTART_VECTOR)
        else $error("acknowledge opcode or vector wrong");
    mem_strobe_a: assert property (memory_write_strobe |-> !wr_b && !cs_b && !io_write_strobe)
        else $error("memory write strobe mismatch");
    io_strobe_a: assert property (io_read_strobe |-> !rd_b && !memory_read_strobe)
        else $error("io read strobe mismatch");
    pin_select_a: assert property (!port_pin0 |-> !cs_b)
        else $error("port pin low without select");
    pin_dummy_a: assert property (!port_pin0 && (!rd_b || !wr_b)
        |-> addr == adc_host_pkg::DUMMY_ADDR)
        else $error("dummy address wrong");
    nibble_split_a: assert property (sample_valid |-> coarse_nibble_voltage == sample_data[7:4]
        && fine_nibble_voltage == sample_data[3:0])
        else $error("nibble split wrong");
    store_range_a: assert property (sample_valid |-> sample_addr >= 8'h20 && sample_addr <= 8'h2F)
        else $error("store address out of range");
    done_idle_a: assert property (done |-> ##[1:2] !busy)
        else $error("busy after done");
endmodule // adc_host_checker

bind adc_bus_host_sequencer adc_host_checker chk (.*);

// ==== converter_model.sv ====
// behavioural model of the converter on the far side of the sequencer
`timescale 1ns/1ps
module converter_model (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // control pins
    input wire logic cs_b,
    input wire logic rd_b,
    input wire logic wr_b,
    // model knobs
    input wire logic mute,
    input wire logic [31:0] conv_cyc,
    // outputs
    output logic intr_b,
    output logic [7:0] db_in
);
    // ==========================================
    // conversion engine
    logic [7:0] latch_r;
    logic [7:0] count_r;
    logic wr_q_r;
    int left_r;
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            latch_r <= 8'h00;
            count_r <= 8'h00;
            wr_q_r <= 1'h1;
            left_r <= 0;
            intr_b <= 1'h1;
        end
        else
        begin
            wr_q_r <= wr_b | cs_b;
            if (!cs_b && !rd_b)
                intr_b <= 1'h1;
            if (!wr_q_r && (wr_b | cs_b))
            begin
                left_r <= conv_cyc;
                intr_b <= 1'h1;
            end
            else if (left_r > 1)
                left_r <= left_r - 1;
            else if (left_r == 1)
            begin
                left_r <= 0;
                if (!mute)
                begin
                    latch_r <= count_r * 8'h1D + 8'h07;
                    count_r <= count_r + 8'h01;
                    intr_b <= 1'h0;
                end
            end
        end
    end
    // released bus shows the inverse of the latch
    assign db_in = (!cs_b && !rd_b) ? latch_r : ~latch_r;
endmodule // converter_model

// ==== adc_bus_host_sequencer_test.sv ====
// self-checking bench for the converter bus host sequencer
`timescale 1ns/1ps
module adc_bus_host_sequencer_test;
    // ==========================================
    // stimulus, wiring and bookkeeping
    logic clk = 1'h0;
    logic rst_b = 1'h0;
    logic go = 1'h0;
    logic [1:0] map_mode = 2'h0;
    logic [2:0] dev_index = 3'h0;
    logic sample_ready = 1'h1;
    logic mute = 1'h0;
    int conv_cyc = 3;
    int errors = 0;
    int compares = 0;
    int cycles = 0;
    int nb = 0;
    logic wr_mem, wr_io, rd_mem, rd_io, pin_lo;
    logic [15:0] wr_addr;
    logic [7:0] got_d[$];
    logic [7:0] got_a[$];
    wire busy, done, timeout, sample_valid, cs_b, rd_b, wr_b, intr_b, port_pin0, inta;
    wire memory_read_strobe, memory_write_strobe, io_read_strobe, io_write_strobe;
    wire [7:0] sample_addr, sample_data, db_in, ack_opcode;
    wire [3:0] coarse_nibble_voltage, fine_nibble_voltage;
    wire [15:0] addr, vector_addr;
    adc_bus_host_sequencer #(.WAIT_LIMIT(50)) dut (.*);
    converter_model far (.*);
    always #20 clk = ~clk;
    // ==========================================
    // monitor and watchdog
    always @(posedge clk)
    begin
        if (sample_valid && sample_ready)
        begin
            got_d.push_back(sample_data);
            got_a.push_back(sample_addr);
        end
        if (!wr_b)
        begin
            wr_addr = addr;
            wr_mem |= memory_write_strobe;
            wr_io |= io_write_strobe;
            pin_lo |= !port_pin0;
        end
        if (!rd_b)
        begin
            rd_mem |= memory_read_strobe;
            rd_io |= io_read_strobe;
        end
        cycles++;
        if (cycles == 20000)
        begin
            errors++;
            wrap_up();
        end
    end
    // ==========================================
    // compare and sequence tasks
    task automatic chk_val(input string what, input logic [15:0] exp, input logic [15:0] got);
        compares++;
        if (got !== exp)
        begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic chk_bit(input string what, input logic exp, input logic got);
        compares++;
        if (got !== exp)
        begin
            errors++;
            $display("[FAIL] %s expected %b seen %b", what, exp, got);
        end
    endtask
    task automatic kick(input logic [1:0] mode, input logic [2:0] idx, input int conv,
                        input logic stall);
        @(negedge clk);
        got_d.delete();
        got_a.delete();
        {wr_mem, wr_io, rd_mem, rd_io, pin_lo} = 5'h00;
        @(posedge clk);
        map_mode <= mode;
        dev_index <= idx;
        conv_cyc <= conv;
        sample_ready <= !stall;
        go <= 1'h1;
        @(posedge clk);
        go <= 1'h0;
    endtask
    task automatic wait_done;
        int n;
        n = 0;
        @(negedge clk);
        while (done !== 1'h1 && n < 3000)
        begin
            @(negedge clk);
            n++;
        end
        chk_bit("done", 1'h1, done);
        repeat (2) @(negedge clk);
        chk_bit("busy", 1'h0, busy);
    endtask
    task automatic check_burst;
        @(posedge clk);
        sample_ready <= 1'h1;
        repeat (80) @(negedge clk);
        chk_val("count", 16'h0010, 16'(got_d.size()));
        for (int k = 0; k < 16; k++)
        begin
            chk_val("addr", 16'h0020 + 16'(k), {8'h00, got_a[k]});
            chk_val("data", {8'h00, 8'(nb + k) * 8'h1D + 8'h07}, {8'h00, got_d[k]});
        end
        nb += 16;
    endtask
    // ==========================================
    // scenarios
    task automatic test_memory;
        kick(adc_host_pkg::MAP_MEMORY, 3'h0, 3, 1'h0);
        wait_done();
        chk_bit("mem write", 1'h1, wr_mem);
        chk_bit("io write", 1'h0, wr_io);
        chk_bit("mem read", 1'h1, rd_mem);
        chk_val("port addr", 16'hE0E0, wr_addr);
        check_burst();
        $display("test memory done");
    endtask
    task automatic test_io_low;
        kick(adc_host_pkg::MAP_IO_LOW, 3'h3, 3, 1'h1);
        repeat (100) @(posedge clk);
        sample_ready <= 1'h1;
        wait_done();
        chk_bit("io write", 1'h1, wr_io);
        chk_bit("mem write", 1'h0, wr_mem);
        chk_val("bit select", 16'h00F7, {8'h00, wr_addr[7:0]});
        check_burst();
        $display("test io low done");
    endtask
    task automatic test_io_high;
        kick(adc_host_pkg::MAP_IO_HIGH, 3'h0, 40, 1'h0);
        wait_done();
        chk_bit("io read", 1'h1, rd_io);
        chk_val("port addr", 16'hE0E0, wr_addr);
        check_burst();
        $display("test io high done");
    endtask
    task automatic test_port_pin;
        kick(adc_host_pkg::MAP_PORT_PIN, 3'h0, 3, 1'h0);
        wait_done();
        chk_bit("pin low", 1'h1, pin_lo);
        chk_val("dummy addr", 16'hFFFF, wr_addr);
        check_burst();
        $display("test port pin done");
    endtask
    task automatic test_timeout;
        @(posedge clk);
        mute <= 1'h1;
        kick(adc_host_pkg::MAP_MEMORY, 3'h0, 3, 1'h0);
        wait_done();
        chk_bit("timeout", 1'h1, timeout);
        @(posedge clk);
        mute <= 1'h0;
        kick(adc_host_pkg::MAP_MEMORY, 3'h0, 3, 1'h0);
        @(negedge clk);
        chk_bit("timeout clear", 1'h0, timeout);
        wait_done();
        chk_bit("io write", 1'h0, wr_io);
        check_burst();
        $display("test timeout done");
    endtask
    task automatic wrap_up;
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial
    begin
        repeat (4) @(posedge clk);
        rst_b <= 1'h1;
        test_memory();
        test_io_low();
        test_io_high();
        test_port_pin();
        test_timeout();
        wrap_up();
    end
endmodule // adc_bus_host_sequencer_test
